// [sim/spsm_rail_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// switched rail model
// ----
module spsm_rail_model (
   input wire logic clk, // core clock
   input wire logic slow, // rails settle late
   input wire logic [spsm_pkg::NSUP-1:0] switch_en, // switches from device
   output logic [spsm_pkg::NSUP-1:0] switch_good // rails valid
);
   logic [spsm_pkg::NSUP-1:0] lag1_q;
   logic [spsm_pkg::NSUP-1:0] lag2_q;
   // a rail ramps for one or two cycles after its switch closes
   always_ff @(posedge clk) begin
      lag1_q <= switch_en;
      lag2_q <= lag1_q;
   end
   // validity drops at once when a switch opens
   assign switch_good = slow ? (switch_en & lag1_q & lag2_q) : (switch_en & lag1_q);
endmodule // spsm_rail_model
`default_nettype wire

// [sim/spsm_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// power sequencer checks
// ----
module spsm_top_asserts (
   input wire logic clk, // core clock
   input wire logic reset_n, // sync reset
   input wire spsm_pkg::spsm_av_rsp_s av_rsp, // bus answer
   input wire logic [spsm_pkg::NSUP-1:0] supply_uv, // rail low
   input wire logic [spsm_pkg::NSUP-1:0] supply_ov, // rail high
   input wire logic [spsm_pkg::NSUP-1:0] switch_good, // switched rails ok
   input wire logic [spsm_pkg::NSUP-1:0] switch_en, // switches
   input wire logic pm_enable, // manager on
   input wire logic core_clk_en, // clock gate
   input wire logic osc_warmup_start, // run pulse
   input wire logic calib_start, // run pulse
   input wire logic link_start, // run pulse
   input wire logic error_out_n, // fault flag
   input wire logic [2:0] power_state // state code
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // entry into run and into saving
   sequence s_run_in;
      power_state != 3'h3 ##1 power_state == 3'h3;
   endsequence
   sequence s_save_in;
      power_state == 3'h3 ##1 power_state == 3'h2;
   endsequence
   a_fault_flag: assert property ((|supply_uv || |supply_ov) |-> ##[1:2] !error_out_n)
      else $error("supply fault not flagged");
   a_flag_release: assert property ($rose(error_out_n) |->
      $past(supply_uv) == '0 && $past(supply_ov) == '0)
      else $error("fault flag released during fault");
   a_boot_step: assert property (power_state == 3'h1 && switch_en != $past(switch_en) |->
      $countones(switch_en) == $countones($past(switch_en)) + 1 ##1 $stable(switch_en) [*8])
      else $error("switches not turned on one by one");
   a_run_good: assert property (s_run_in |-> $past(switch_good) == '1)
      else $error("run entered with bad rail");
   a_run_from: assert property (s_run_in |-> $past(power_state) inside {3'h1, 3'h5})
      else $error("run entered from wrong state");
   a_run_pulse: assert property (s_run_in |-> ##[0:1] (osc_warmup_start && calib_start && link_start))
      else $error("run entry pulses missing");
   a_pulse_once: assert property (osc_warmup_start |=> !osc_warmup_start)
      else $error("warmup pulse too long");
   a_save_sleep: assert property (s_save_in |-> ##[1:12] power_state == 3'h7)
      else $error("sleep not reached after saving");
   a_saved_off: assert property (power_state == 3'h6 |-> ##[0:1] (switch_en == '0 && !pm_enable))
      else $error("saved state left power on");
   a_sleep_quiet: assert property (power_state == 3'h7 ##1 power_state == 3'h7 |->
      !core_clk_en && switch_en == '0)
      else $error("sleep with clock or switch on");
   a_save_from: assert property ($changed(power_state) && power_state == 3'h2 |->
      $past(power_state) inside {3'h3, 3'h5})
      else $error("saving entered from wrong state");
   a_ack_one: assert property (!av_rsp.waitrequest |=> av_rsp.waitrequest)
      else $error("answer longer than one cycle");
endmodule // spsm_top_asserts
bind spsm_top spsm_top_asserts u_chk (.clk(clk), .reset_n(reset_n), .av_rsp(av_rsp),
   .supply_uv(supply_uv), .supply_ov(supply_ov), .switch_good(switch_good),
   .switch_en(switch_en), .pm_enable(pm_enable), .core_clk_en(core_clk_en),
   .osc_warmup_start(osc_warmup_start), .calib_start(calib_start), .link_start(link_start),
   .error_out_n(error_out_n), .power_state(power_state));
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// bench top
// ----
module testbench;
   logic clk;
   logic reset_n;
   logic slow;
   logic remote_wake_a;
   logic remote_wake_b;
   spsm_pkg::spsm_av_req_s av_req;
   spsm_pkg::spsm_av_rsp_s av_rsp;
   logic [spsm_pkg::NSUP-1:0] supply_uv, supply_ov, switch_good, switch_en;
   logic pm_enable, core_clk_en, osc_warmup_start, calib_start, link_start, link_hold;
   logic error_out_n;
   logic [2:0] power_state;
   logic [31:0] rd;
   int n_errors = 0;
   int total_checks = 0;
   int n_pulse = 0;
   int n;
   int ord[4] = '{2, 0, 3, 1};
   // device and its rails
   spsm_top uut (.clk(clk), .reset_n(reset_n), .av_req(av_req), .av_rsp(av_rsp),
      .supply_uv(supply_uv), .supply_ov(supply_ov), .switch_good(switch_good),
      .remote_wake_a(remote_wake_a), .remote_wake_b(remote_wake_b), .switch_en(switch_en),
      .pm_enable(pm_enable), .core_clk_en(core_clk_en), .osc_warmup_start(osc_warmup_start),
      .calib_start(calib_start), .link_start(link_start), .link_hold(link_hold),
      .error_out_n(error_out_n), .power_state(power_state));
   spsm_rail_model far (.clk(clk), .slow(slow), .switch_en(switch_en),
      .switch_good(switch_good));
   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // count run-entry pulses
   always @(posedge clk)
      if (osc_warmup_start === 1'b1)
         n_pulse <= n_pulse + 1;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // a wait that ran out ends the run
   task automatic give_up();
      n_errors++;
      $display("MISMATCH t=%0t wait ran out", $time);
      report_and_stop();
   endtask
   // one access, held until the rising edge that samples waitrequest low
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge clk);
      av_req.read <= !wr;
      av_req.write <= wr;
      av_req.address <= a;
      av_req.writedata <= wd;
      do begin
         @(posedge clk);
         k++;
      end while (av_rsp.waitrequest !== 1'b0 && k < 4000);
      if (k >= 4000)
         give_up();
      rd = av_rsp.readdata;
      av_req.read <= 1'b0;
      av_req.write <= 1'b0;
   endtask
   task automatic wait_state(input logic [2:0] s);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (power_state !== s && k < 4000);
      if (k >= 4000)
         give_up();
   endtask
   function automatic logic [5:0] cfg_a(input int i);
      return spsm_pkg::OFF_CFG0 + 6'(4 * i);
   endfunction
   // main sequence
   initial begin
      reset_n = 1'b0;
      slow = 1'b0;
      remote_wake_a = 1'b0;
      remote_wake_b = 1'b0;
      supply_uv = '1;
      supply_ov = '0;
      av_req = {2'b00, 6'h00, 4'hf, 32'h0};
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         repeat (5) @(negedge clk);
         chk(power_state, 3'h0);
         @(posedge clk);
         supply_uv[ord[i]] <= 1'b0;
      end
      wait_state(3'h1);
      for (int i = 0; i < 4; i++) begin
         n = 0;
         while (switch_en !== 4'((1 << (i + 1)) - 1) && n < 100) begin
            @(negedge clk);
            n++;
         end
         chk(32'(n >= 39 && n <= 41), 32'h1);
      end
      wait_state(3'h3);
      repeat (2) @(negedge clk);
      chk(n_pulse, 1);
      xfer(1'b1, spsm_pkg::OFF_DIAG0, 32'hf);
      repeat (3) @(negedge clk);
      chk(error_out_n, 1'b1);
      xfer(1'b0, spsm_pkg::OFF_STATUS, 32'h0);
      chk(rd & 32'hff07, 32'hff03);
      $display("boot test done");
      xfer(1'b1, spsm_pkg::OFF_SCRATCH, 32'h5a5a_1234);
      xfer(1'b0, spsm_pkg::OFF_SCRATCH, 32'h0);
      chk(rd, 32'h5a5a_1234);
      xfer(1'b1, 6'h3c, 32'hffff_ffff);
      xfer(1'b0, 6'h3c, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b1, spsm_pkg::OFF_CTRL, 32'h1c);
      xfer(1'b0, spsm_pkg::OFF_SCRATCH, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b0, spsm_pkg::OFF_CTRL, 32'h0);
      chk(rd, 32'hc);
      for (int i = 0; i < 4; i++)
         xfer(1'b1, cfg_a(i), 32'hc0de_0000 + 32'(i));
      $display("register test done");
      for (int j = 0; j < 2; j++) begin
         @(posedge clk);
         if (j == 0)
            supply_uv <= 4'h4;
         else
            supply_ov <= 4'h2;
         repeat (3) @(posedge clk);
         supply_uv <= '0;
         supply_ov <= '0;
         @(negedge clk);
         chk(error_out_n, 1'b0);
         xfer(1'b0, j ? spsm_pkg::OFF_DIAG1 : spsm_pkg::OFF_DIAG0, 32'h0);
         chk(rd, j ? 32'h2 : 32'h4);
         xfer(1'b1, j ? spsm_pkg::OFF_DIAG1 : spsm_pkg::OFF_DIAG0, rd);
         repeat (3) @(negedge clk);
         chk(error_out_n, 1'b1);
      end
      $display("fault test done");
      xfer(1'b1, spsm_pkg::OFF_CTRL, 32'h0);
      xfer(1'b1, spsm_pkg::OFF_CTRL, 32'h2);
      xfer(1'b1, spsm_pkg::OFF_CTRL, 32'h3);
      wait_state(3'h7);
      repeat (2) @(negedge clk);
      chk({switch_en, pm_enable, core_clk_en, link_hold}, 7'h01);
      @(posedge clk);
      remote_wake_a <= 1'b1;
      repeat (5) @(posedge clk);
      remote_wake_a <= 1'b0;
      @(negedge clk);
      chk(power_state, 3'h7);
      slow <= 1'b1;
      xfer(1'b0, spsm_pkg::OFF_CTRL, 32'h0);
      chk(rd, 32'h3);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, cfg_a(i), 32'h0);
         chk(rd, 32'hc0de_0000 + 32'(i));
      end
      xfer(1'b1, spsm_pkg::OFF_CTRL, 32'h2);
      xfer(1'b1, spsm_pkg::OFF_CTRL, 32'hc);
      @(negedge clk);
      chk(link_hold, 1'b0);
      slow <= 1'b0;
      $display("local sleep test done");
      for (int j = 0; j < 2; j++) begin
         xfer(1'b1, spsm_pkg::OFF_CTRL, j ? 32'h9 : 32'h5);
         wait_state(3'h7);
         @(posedge clk);
         if (j == 0)
            remote_wake_a <= 1'b1;
         else
            remote_wake_b <= 1'b1;
         wait_state(3'h3);
         chk(core_clk_en, 1'b1);
         @(posedge clk);
         remote_wake_a <= 1'b0;
         remote_wake_b <= 1'b0;
         xfer(1'b1, spsm_pkg::OFF_CTRL, 32'hc);
      end
      $display("remote wake test done");
      xfer(1'b1, spsm_pkg::OFF_CTRL, 32'h1c);
      wait_state(3'h7);
      xfer(1'b0, spsm_pkg::OFF_CTRL, 32'h0);
      chk(rd, 32'h9);
      xfer(1'b0, cfg_a(0), 32'h0);
      chk(rd, 32'hc0de_0000);
      xfer(1'b1, spsm_pkg::OFF_CTRL, 32'hc);
      $display("soft reset test done");
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire

// [src/spsm_pkg.sv]
// Overview of operation
// - flag supply faults, drive error_out_n low
// - supply valid status readable by host
// - auto power-up, supplies valid any order
// - boot from reset or wake, all on
// - leave boot only when switched supplies good
// - core switches turned on one by one
// - run entry starts oscillator, calibration, link
// - low-power request saves configuration to retention
// - saved state: switches off, manager disabled
// - sleep follows saving with no command
// - sleep keeps supplies off, clocks stopped
// - wakeup restores configuration from retention automatically
// - any bus access wakes; host clears later
// - self-clearing global soft reset to defaults
// - soft reset after sleep reloads retention
package spsm_pkg;
   // ----------------------------------------------------------
   // sizes
   // ----------------------------------------------------------
   localparam int NSUP = 4;
   localparam int NCFG = 4;
   localparam int RET_DEPTH = 8;
   localparam int RET_AW = 3;
   localparam int ADDR_W = 6;
   // ----------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h04;
   localparam logic [ADDR_W-1:0] OFF_DIAG0 = 6'h08;
   localparam logic [ADDR_W-1:0] OFF_DIAG1 = 6'h0c;
   localparam logic [ADDR_W-1:0] OFF_CFG0 = 6'h10;
   localparam logic [ADDR_W-1:0] OFF_CFG1 = 6'h14;
   localparam logic [ADDR_W-1:0] OFF_CFG2 = 6'h18;
   localparam logic [ADDR_W-1:0] OFF_CFG3 = 6'h1c;
   localparam logic [ADDR_W-1:0] OFF_SCRATCH = 6'h20;
   // ----------------------------------------------------------
   // control fields and reset values
   // ----------------------------------------------------------
   localparam int CTRL_LOWPWR = 0;
   localparam int CTRL_LINKHOLD = 1;
   localparam int CTRL_WAKEA = 2;
   localparam int CTRL_WAKEB = 3;
   localparam int CTRL_SOFTRST = 4;
   localparam logic RST_WAKE_EN = 1'b1;
   localparam logic [31:0] RST_CFG = 32'h0000_0000;
   // ----------------------------------------------------------
   // timing: switch step is a least time, rounded up
   // ----------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int SWITCH_STEP_NS = 2000;
   localparam int SWITCH_STEP_CYC = (SWITCH_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STEP_W = $clog2(SWITCH_STEP_CYC + 1);
   // ----------------------------------------------------------
   // types
   // ----------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RESET   = 3'h0,
      ST_BOOT    = 3'h1,
      ST_RUN     = 3'h3,
      ST_SAVE    = 3'h2,
      ST_SAVED   = 3'h6,
      ST_SLEEP   = 3'h7,
      ST_RESTORE = 3'h5
   } spsm_state_e;

   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } spsm_av_req_s;

   typedef struct packed {
      logic waitrequest;
      logic [31:0] readdata;
   } spsm_av_rsp_s;

   typedef struct packed {
      logic we;
      logic [RET_AW-1:0] waddr;
      logic [31:0] wdata;
      logic [RET_AW-1:0] raddr;
   } spsm_mem_req_s;
endpackage

// [src/spsm_ret_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module spsm_ret_mem #(
   parameter int W = 32,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic clk,                     // core clock
   input wire logic reset_n,                 // sync reset, read register only
   input wire spsm_pkg::spsm_mem_req_s req,  // write and read port
   output logic [W-1:0] rdata                // registered read data
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [W-1:0] rdata;
   } spsm_mem_st_s;

   spsm_mem_st_s q;
   spsm_mem_st_s d;

   // ----------------------------------------------------------
   // contents survive reset, only the read register clears
   // ----------------------------------------------------------
   always_comb begin
      d = q;
      d.rdata = q.mem[req.raddr];
      if (req.we) begin
         d.mem[req.waddr] = req.wdata;
      end
      if (!reset_n) begin
         d.rdata = '0;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      q <= d;
   end

   assign rdata = q.rdata;
endmodule // spsm_ret_mem
`default_nettype wire

// [src/spsm_top.sv]
`timescale 1ns/1ps
`default_nettype none
module spsm_top (
   input wire logic clk,                          // reference clock, 20 MHz
   input wire logic reset_n,                      // power-up reset, sync, active low
   input wire spsm_pkg::spsm_av_req_s av_req,     // avalon-mm request
   output spsm_pkg::spsm_av_rsp_s av_rsp,         // avalon-mm answer
   input wire logic [spsm_pkg::NSUP-1:0] supply_uv,   // undervoltage per rail
   input wire logic [spsm_pkg::NSUP-1:0] supply_ov,   // overvoltage per rail
   input wire logic [spsm_pkg::NSUP-1:0] switch_good, // post-switch rail valid
   input wire logic remote_wake_a,                // wake request from link a
   input wire logic remote_wake_b,                // wake request from link b
   output logic [spsm_pkg::NSUP-1:0] switch_en,   // core power switches
   output logic pm_enable,                        // manager sub-blocks on
   output logic core_clk_en,                      // core clock gate
   output logic osc_warmup_start,                 // pulse on run entry
   output logic calib_start,                      // pulse on run entry
   output logic link_start,                       // pulse on run entry
   output logic link_hold,                        // link held in reset
   output logic error_out_n,                      // supply failure, active low
   output logic [2:0] power_state                 // current state code
);
   localparam int N = spsm_pkg::NSUP;
   localparam logic [spsm_pkg::STEP_W-1:0] STEP_LAST =
      spsm_pkg::STEP_W'(spsm_pkg::SWITCH_STEP_CYC - 1);
   localparam logic [spsm_pkg::RET_AW-1:0] SAVE_LAST = spsm_pkg::RET_AW'(spsm_pkg::NCFG);
   localparam logic [spsm_pkg::RET_AW-1:0] REST_LAST =
      spsm_pkg::RET_AW'(spsm_pkg::NCFG + 1);

   typedef struct packed {
      spsm_pkg::spsm_state_e state;
      logic low_power;
      logic link_hold;
      logic wake_en_a;
      logic wake_en_b;
      logic [spsm_pkg::NCFG-1:0][31:0] cfg;
      logic [31:0] scratch;
      logic [N-1:0] diag_uv;
      logic [N-1:0] diag_ov;
      logic [N-1:0] sw_en;
      logic [spsm_pkg::STEP_W-1:0] step;
      logic [spsm_pkg::RET_AW-1:0] idx;
      logic resume;
      logic from_srst;
      logic ret_valid;
      logic pm_en;
      logic clk_en;
      logic err_n;
      logic osc_start;
      logic cal_start;
      logic link_start;
      spsm_pkg::spsm_av_rsp_s rsp;
      spsm_pkg::spsm_mem_req_s mem;
   } spsm_top_st_s;

   spsm_top_st_s q;
   spsm_top_st_s n;
   logic [31:0] mem_rdata;
   logic [N-1:0] ext_ok;
   logic busy;
   logic [31:0] ctrl_word;

   // ----------------------------------------------------------
   // byte-lane merge for writes
   // ----------------------------------------------------------
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------
   // retention memory
   // ----------------------------------------------------------
   spsm_ret_mem #(
      .W(32),
      .DEPTH(spsm_pkg::RET_DEPTH),
      .AW(spsm_pkg::RET_AW)
   ) u_ret_mem (
      .clk(clk),
      .reset_n(reset_n),
      .req(q.mem),
      .rdata(mem_rdata)
   );

   // rail validity and bus stall
   assign ext_ok = ~supply_uv & ~supply_ov;
   assign ctrl_word = {28'h0000000, q.wake_en_b, q.wake_en_a, q.link_hold, q.low_power};
   assign busy = !((q.state == spsm_pkg::ST_RUN) ||
                   (!q.resume && (q.state == spsm_pkg::ST_RESET ||
                                  q.state == spsm_pkg::ST_BOOT)));

   // ----------------------------------------------------------
   // next state: bus slave, supervision, sequencer
   // ----------------------------------------------------------
   always_comb begin
      logic wr_done;
      logic lp_set;
      logic srst;
      logic wake;
      logic [N-1:0] clr_uv;
      logic [N-1:0] clr_ov;
      wr_done = 1'b0;
      lp_set = 1'b0;
      srst = 1'b0;
      wake = 1'b0;
      clr_uv = '0;
      clr_ov = '0;
      n = q;
      n.osc_start = 1'b0;
      n.cal_start = 1'b0;
      n.link_start = 1'b0;
      n.mem.we = 1'b0;
      n.rsp.waitrequest = 1'b1;
      wr_done = !q.rsp.waitrequest && av_req.write;
      // bus: a write lands on the edge that sees waitrequest low
      if (wr_done) begin
         case (av_req.address)
            spsm_pkg::OFF_CTRL: begin
               if (av_req.byteenable[0]) begin
                  n.low_power = av_req.writedata[spsm_pkg::CTRL_LOWPWR];
                  n.link_hold = av_req.writedata[spsm_pkg::CTRL_LINKHOLD];
                  n.wake_en_a = av_req.writedata[spsm_pkg::CTRL_WAKEA];
                  n.wake_en_b = av_req.writedata[spsm_pkg::CTRL_WAKEB];
                  lp_set = av_req.writedata[spsm_pkg::CTRL_LOWPWR];
                  srst = av_req.writedata[spsm_pkg::CTRL_SOFTRST];
               end
            end
            spsm_pkg::OFF_DIAG0: begin
               if (av_req.byteenable[0]) begin
                  clr_uv = av_req.writedata[N-1:0];
               end
            end
            spsm_pkg::OFF_DIAG1: begin
               if (av_req.byteenable[0]) begin
                  clr_ov = av_req.writedata[N-1:0];
               end
            end
            spsm_pkg::OFF_CFG0, spsm_pkg::OFF_CFG1,
            spsm_pkg::OFF_CFG2, spsm_pkg::OFF_CFG3: begin
               n.cfg[av_req.address[3:2]] =
                  be_merge(q.cfg[av_req.address[3:2]], av_req.writedata, av_req.byteenable);
            end
            spsm_pkg::OFF_SCRATCH: begin
               n.scratch = be_merge(q.scratch, av_req.writedata, av_req.byteenable);
            end
            default: begin
            end
         endcase
      end else if (q.rsp.waitrequest && (av_req.read || av_req.write) && !busy) begin
         n.rsp.waitrequest = 1'b0;
         if (av_req.read) begin
            case (av_req.address)
               spsm_pkg::OFF_CTRL: n.rsp.readdata = ctrl_word;
               spsm_pkg::OFF_STATUS: n.rsp.readdata = {16'h0000, switch_good, ext_ok, 3'h0,
                                                       q.ret_valid, q.resume, q.state};
               spsm_pkg::OFF_DIAG0: n.rsp.readdata = {28'h0000000, q.diag_uv};
               spsm_pkg::OFF_DIAG1: n.rsp.readdata = {28'h0000000, q.diag_ov};
               spsm_pkg::OFF_CFG0, spsm_pkg::OFF_CFG1,
               spsm_pkg::OFF_CFG2, spsm_pkg::OFF_CFG3:
                  n.rsp.readdata = q.cfg[av_req.address[3:2]];
               spsm_pkg::OFF_SCRATCH: n.rsp.readdata = q.scratch;
               default: n.rsp.readdata = 32'h0000_0000;
            endcase
         end
      end
      // supervision in every state, a new fault beats a clear
      n.diag_uv = (q.diag_uv & ~clr_uv) | supply_uv;
      n.diag_ov = (q.diag_ov & ~clr_ov) | supply_ov;
      n.err_n = ~(|n.diag_uv || |n.diag_ov);
      // any bus access or an allowed remote request ends sleep
      wake = av_req.read || av_req.write ||
             (remote_wake_a && q.wake_en_a) || (remote_wake_b && q.wake_en_b);
      // sequencer
      case (q.state)
         spsm_pkg::ST_RESET: begin
            n.sw_en = '0;
            n.step = '0;
            if (&ext_ok) begin
               n.state = spsm_pkg::ST_BOOT;
            end
         end
         spsm_pkg::ST_BOOT: begin
            n.pm_en = 1'b1;
            n.clk_en = 1'b1;
            if (!(&q.sw_en)) begin
               if (q.step == STEP_LAST) begin
                  n.step = '0;
                  n.sw_en = {q.sw_en[N-2:0], 1'b1};
               end else begin
                  n.step = q.step + 1'b1;
               end
            end else if (&switch_good) begin
               if (q.resume) begin
                  n.state = spsm_pkg::ST_RESTORE;
                  n.idx = '0;
                  n.mem.raddr = '0;
               end else begin
                  n.state = spsm_pkg::ST_RUN;
               end
            end
         end
         spsm_pkg::ST_RUN: begin
            n.resume = 1'b0;
            if (srst) begin
               n.cfg = {spsm_pkg::NCFG{spsm_pkg::RST_CFG}};
               n.scratch = spsm_pkg::RST_CFG;
               n.low_power = 1'b0;
               n.link_hold = 1'b0;
               n.wake_en_a = spsm_pkg::RST_WAKE_EN;
               n.wake_en_b = spsm_pkg::RST_WAKE_EN;
               if (q.ret_valid) begin
                  n.state = spsm_pkg::ST_RESTORE;
                  n.from_srst = 1'b1;
                  n.idx = '0;
                  n.mem.raddr = '0;
               end
            end else if (lp_set || (q.from_srst && q.low_power)) begin
               n.from_srst = 1'b0;
               n.state = spsm_pkg::ST_SAVE;
               n.idx = '0;
            end else begin
               n.from_srst = 1'b0;
            end
         end
         spsm_pkg::ST_SAVE: begin
            n.mem.we = 1'b1;
            n.mem.waddr = q.idx;
            n.mem.wdata = (q.idx == '0) ? ctrl_word : q.cfg[2'(q.idx - 3'h1)];
            if (q.idx == SAVE_LAST) begin
               n.ret_valid = 1'b1;
               n.state = spsm_pkg::ST_SAVED;
            end else begin
               n.idx = q.idx + 1'b1;
            end
         end
         spsm_pkg::ST_SAVED: begin
            n.sw_en = '0;
            n.pm_en = 1'b0;
            n.state = spsm_pkg::ST_SLEEP;
         end
         spsm_pkg::ST_SLEEP: begin
            n.sw_en = '0;
            n.clk_en = 1'b0;
            n.pm_en = 1'b0;
            n.step = '0;
            if (wake) begin
               n.resume = 1'b1;
               n.state = spsm_pkg::ST_BOOT;
            end
         end
         spsm_pkg::ST_RESTORE: begin
            n.mem.raddr = q.idx + 1'b1;
            n.idx = q.idx + 1'b1;
            if (q.idx == 3'h1) begin
               n.low_power = mem_rdata[spsm_pkg::CTRL_LOWPWR];
               n.link_hold = mem_rdata[spsm_pkg::CTRL_LINKHOLD];
               n.wake_en_a = mem_rdata[spsm_pkg::CTRL_WAKEA];
               n.wake_en_b = mem_rdata[spsm_pkg::CTRL_WAKEB];
            end else if (q.idx != '0) begin
               n.cfg[2'(q.idx - 3'h2)] = mem_rdata;
            end
            if (q.idx == REST_LAST) begin
               n.state = spsm_pkg::ST_RUN;
            end
         end
         default: begin
            n.state = spsm_pkg::ST_RESET;
         end
      endcase
      // run entry kicks oscillator, calibration and link
      if (n.state == spsm_pkg::ST_RUN && q.state != spsm_pkg::ST_RUN) begin
         n.osc_start = 1'b1;
         n.cal_start = 1'b1;
         n.link_start = 1'b1;
      end
      // power-up reset, retention validity forgotten
      if (!reset_n) begin
         n = '0;
         n.state = spsm_pkg::ST_RESET;
         n.wake_en_a = spsm_pkg::RST_WAKE_EN;
         n.wake_en_b = spsm_pkg::RST_WAKE_EN;
         n.cfg = {spsm_pkg::NCFG{spsm_pkg::RST_CFG}};
         n.scratch = spsm_pkg::RST_CFG;
         n.err_n = 1'b1;
         n.rsp.waitrequest = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      q <= n;
   end

   // ----------------------------------------------------------
   // outputs straight from the state register
   // ----------------------------------------------------------
   assign av_rsp = q.rsp;
   assign switch_en = q.sw_en;
   assign pm_enable = q.pm_en;
   assign core_clk_en = q.clk_en;
   assign osc_warmup_start = q.osc_start;
   assign calib_start = q.cal_start;
   assign link_start = q.link_start;
   assign link_hold = q.link_hold;
   assign error_out_n = q.err_n;
   assign power_state = q.state;
endmodule // spsm_top
`default_nettype wire
